// ===== shared/ebc_pkg.sv
// constants and types for the eeprom byte access controller
package ebc_pkg;
	// ***********************************************************
	// register map and field positions
	// ***********************************************************
	localparam logic [1:0] REG_ADDR_LOW  = 2'h0;
	localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
	localparam logic [1:0] REG_DATA      = 2'h2;
	localparam logic [1:0] REG_CONTROL   = 2'h3;
	localparam int CTL_MODE_HI = 5;
	localparam int CTL_MODE_LO = 4;
	localparam int CTL_RIE     = 3;
	localparam int CTL_MPE     = 2;
	localparam int CTL_PE      = 1;
	localparam int CTL_RE      = 0;
	localparam int ADDR_W      = 12;
	localparam int DATA_W      = 8;
	localparam int MEM_DEPTH   = 4096;

	// ***********************************************************
	// reset values, modes and fixed patterns
	// ***********************************************************
	localparam logic [11:0] ADDR_RESET  = 12'h000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [1:0]  MODE_ATOMIC = 2'b00;
	localparam logic [1:0]  MODE_ERASE  = 2'b01;
	localparam logic [1:0]  MODE_WRITE  = 2'b10;
	localparam logic [1:0]  MODE_RSVD   = 2'b11;

	// ***********************************************************
	// timing: cpu clock cycles, microseconds and rc oscillator ticks
	// ***********************************************************
	localparam logic [2:0] MPE_WINDOW  = 3'h4;
	localparam logic [2:0] STALL_WRITE = 3'h2;
	localparam logic [2:0] STALL_READ  = 3'h4;
	localparam int ATOMIC_US        = 3400;
	localparam int SPLIT_US         = 1800;
	localparam int RC_ATOMIC_TICKS  = 26368;
	// split modes scale the atomic tick count, rounded up
	localparam int RC_SPLIT_TICKS   =
		(SPLIT_US * RC_ATOMIC_TICKS + ATOMIC_US - 1) / ATOMIC_US;
	localparam int TICK_W           = 15;

	typedef enum logic [1:0] {
		ENG_IDLE   = 2'b00,
		ENG_WAIT   = 2'b01,
		ENG_COMMIT = 2'b10
	} ebc_eng_t;
endpackage

// ===== shared/ebc_mem_if.sv
// link between the controller and its byte array
`timescale 1ns/10ps
interface ebc_mem_if import ebc_pkg::*; ();
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              we;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// ===== hw/ebc_mem.sv
// 4k by 8 data array with registered read port
`timescale 1ns/10ps
module ebc_mem
	import ebc_pkg::*;
(
	input  wire logic clk_i,
	ebc_mem_if.mem    port
);
	logic [DATA_W-1:0] store [0:MEM_DEPTH-1];
	logic [DATA_W-1:0] rdata_reg;

	// write on strobe, read always; read of a written cell gives old byte
	always_ff @(posedge clk_i) begin
		if (port.we) begin
			store[port.addr] <= port.wdata;
		end
		rdata_reg <= store[port.addr];
	end

	assign port.rdata = rdata_reg;
endmodule

// ===== hw/ebc_ctrl.sv
// cpu-side controller for single byte eeprom reads and programming
`timescale 1ns/10ps
module ebc_ctrl
	import ebc_pkg::*;
#(
	parameter int ATOMIC_TICKS = RC_ATOMIC_TICKS,
	parameter int SPLIT_TICKS  = RC_SPLIT_TICKS
) (
	input  wire logic       CLK_I,
	input  wire logic       RST_I,
	input  wire logic       POR_I,
	input  wire logic [1:0] IO_SEL_I,
	input  wire logic       IO_WR_I,
	input  wire logic       IO_RD_I,
	input  wire logic [7:0] IO_WDATA_I,
	output logic      [7:0] IO_RDATA_O,
	input  wire logic       GIE_I,
	input  wire logic       FLASH_SELFPROG_I,
	input  wire logic       RC_TICK_I,
	output logic            IRQ_READY_O,
	output logic            CPU_STALL_O
);
	// ***********************************************************
	// declarations
	// ***********************************************************
	ebc_mem_if mem_port ();

	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [1:0]        mode_reg;
	logic              rie_reg;
	logic              mpe_reg;
	logic [2:0]        mpe_cnt_reg;
	logic              re_reg;
	logic              busy_reg;
	logic [2:0]        stall_cnt_reg;
	ebc_eng_t          eng_reg;
	ebc_eng_t          eng_next;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [TICK_W-1:0] tick_target;
	logic [ADDR_W-1:0] lat_addr_reg;
	logic [DATA_W-1:0] lat_data_reg;
	logic [1:0]        lat_mode_reg;
	logic              rc_s1_reg;
	logic              rc_s2_reg;
	logic              rc_s3_reg;
	logic              rc_level_reg;
	logic              rc_tick;
	logic              ctl_wr;
	logic              prog_accept;
	logic              rd_accept;
	logic [1:0]        new_mode;
	logic [DATA_W-1:0] commit_byte;

	// ***********************************************************
	// register decode
	// ***********************************************************
	assign ctl_wr   = IO_WR_I && (IO_SEL_I == REG_CONTROL);
	// mode written together with the strobe still counts
	assign new_mode = busy_reg ? mode_reg
		: IO_WDATA_I[CTL_MODE_HI:CTL_MODE_LO];
	// reserved mode code never starts programming
	assign prog_accept = ctl_wr && IO_WDATA_I[CTL_PE] && mpe_reg
		&& !busy_reg && (new_mode != MODE_RSVD);
	assign rd_accept = ctl_wr && IO_WDATA_I[CTL_RE] && !busy_reg;

	// address register, frozen while programming runs
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			addr_reg <= ADDR_RESET;
		end else if (IO_WR_I && !busy_reg) begin
			if (IO_SEL_I == REG_ADDR_LOW) begin
				addr_reg[7:0] <= IO_WDATA_I;
			end else if (IO_SEL_I == REG_ADDR_HIGH) begin
				addr_reg[11:8] <= IO_WDATA_I[3:0];
			end
		end
	end

	// data register: cpu writes it, a read loads it
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			data_reg <= BYTE_RESET;
		end else if (re_reg) begin
			data_reg <= mem_port.rdata;
		end else if (IO_WR_I && IO_SEL_I == REG_DATA) begin
			data_reg <= IO_WDATA_I;
		end
	end

	// mode survives a reset taken during programming, so it is
	// cleared synchronously and only power-on clears it outright
	always_ff @(posedge CLK_I or posedge POR_I) begin
		if (POR_I) begin
			mode_reg <= MODE_ATOMIC;
		end else if (RST_I) begin
			if (!busy_reg) begin
				mode_reg <= MODE_ATOMIC;
			end
		end else if (ctl_wr && !busy_reg) begin
			mode_reg <= IO_WDATA_I[CTL_MODE_HI:CTL_MODE_LO];
		end
	end

	// interrupt enable bit
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rie_reg <= 1'b0;
		end else if (ctl_wr) begin
			rie_reg <= IO_WDATA_I[CTL_RIE];
		end
	end

	// master enable: writing one reloads the window, zero is ignored
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mpe_reg     <= 1'b0;
			mpe_cnt_reg <= 3'h0;
		end else if (ctl_wr && IO_WDATA_I[CTL_MPE]) begin
			mpe_reg     <= 1'b1;
			mpe_cnt_reg <= MPE_WINDOW;
		end else if (mpe_cnt_reg == 3'h1) begin
			mpe_reg     <= 1'b0;
			mpe_cnt_reg <= 3'h0;
		end else if (mpe_cnt_reg != 3'h0) begin
			mpe_cnt_reg <= mpe_cnt_reg - 3'h1;
		end
	end

	// read strobe stands one cycle while the array answers
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			re_reg <= 1'b0;
		end else begin
			re_reg <= rd_accept;
		end
	end

	// cpu stall counter, two cycles for write, four for read
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			stall_cnt_reg <= 3'h0;
			CPU_STALL_O   <= 1'b0;
		end else if (prog_accept) begin
			stall_cnt_reg <= STALL_WRITE;
			CPU_STALL_O   <= 1'b1;
		end else if (rd_accept) begin
			stall_cnt_reg <= STALL_READ;
			CPU_STALL_O   <= 1'b1;
		end else if (stall_cnt_reg > 3'h1) begin
			stall_cnt_reg <= stall_cnt_reg - 3'h1;
		end else begin
			stall_cnt_reg <= 3'h0;
			CPU_STALL_O   <= 1'b0;
		end
	end

	// ***********************************************************
	// rc oscillator tick synchroniser
	// ***********************************************************
	// a rise counts once the second and third stages agree
	always_ff @(posedge CLK_I or posedge POR_I) begin
		if (POR_I) begin
			rc_s1_reg    <= 1'b0;
			rc_s2_reg    <= 1'b0;
			rc_s3_reg    <= 1'b0;
			rc_level_reg <= 1'b0;
		end else begin
			rc_s1_reg <= RC_TICK_I;
			rc_s2_reg <= rc_s1_reg;
			rc_s3_reg <= rc_s2_reg;
			if (rc_s2_reg == rc_s3_reg) begin
				rc_level_reg <= rc_s3_reg;
			end
		end
	end
	assign rc_tick = (rc_s2_reg == rc_s3_reg) && rc_s3_reg
		&& !rc_level_reg;

	// ***********************************************************
	// programming engine, kept alive across a cpu reset
	// ***********************************************************
	assign tick_target = (lat_mode_reg == MODE_ATOMIC)
		? TICK_W'(ATOMIC_TICKS) : TICK_W'(SPLIT_TICKS);

	// next state of the engine
	always_comb begin
		eng_next = eng_reg;
		case (eng_reg)
			ENG_IDLE: begin
				if (prog_accept) begin
					eng_next = ENG_WAIT;
				end
			end
			ENG_WAIT: begin
				// flash self-programming holds the timer
				if (rc_tick && !FLASH_SELFPROG_I
					&& tick_cnt_reg == tick_target - TICK_W'(1)) begin
					eng_next = ENG_COMMIT;
				end
			end
			ENG_COMMIT: begin
				eng_next = ENG_IDLE;
			end
			default: begin
				eng_next = ENG_IDLE;
			end
		endcase
	end

	// state, busy flag, tick timer and latched operands
	always_ff @(posedge CLK_I or posedge POR_I) begin
		if (POR_I) begin
			eng_reg      <= ENG_IDLE;
			busy_reg     <= 1'b0;
			tick_cnt_reg <= '0;
			lat_addr_reg <= ADDR_RESET;
			lat_data_reg <= BYTE_RESET;
			lat_mode_reg <= MODE_ATOMIC;
		end else begin
			eng_reg <= eng_next;
			if (prog_accept && eng_reg == ENG_IDLE) begin
				busy_reg     <= 1'b1;
				tick_cnt_reg <= '0;
				lat_addr_reg <= addr_reg;
				lat_data_reg <= data_reg;
				lat_mode_reg <= new_mode;
			end else if (eng_reg == ENG_COMMIT) begin
				busy_reg <= 1'b0;
			end else if (eng_reg == ENG_WAIT && rc_tick
				&& !FLASH_SELFPROG_I) begin
				tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
			end
		end
	end

	// erase gives all ones; write only can just clear bits
	always_comb begin
		case (lat_mode_reg)
			MODE_ERASE: commit_byte = ERASED_BYTE;
			MODE_WRITE: commit_byte = lat_data_reg & mem_port.rdata;
			default:    commit_byte = lat_data_reg;
		endcase
	end

	// array stays on the latched address while busy
	assign mem_port.addr  = busy_reg ? lat_addr_reg : addr_reg;
	assign mem_port.wdata = commit_byte;
	assign mem_port.we    = (eng_reg == ENG_COMMIT);

	ebc_mem u_mem (
		.clk_i (CLK_I),
		.port  (mem_port.mem)
	);

	// ***********************************************************
	// read back and ready interrupt
	// ***********************************************************
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IO_RDATA_O <= BYTE_RESET;
		end else if (IO_RD_I) begin
			case (IO_SEL_I)
				REG_ADDR_LOW:  IO_RDATA_O <= addr_reg[7:0];
				REG_ADDR_HIGH: IO_RDATA_O <= {4'h0, addr_reg[11:8]};
				REG_DATA:      IO_RDATA_O <= data_reg;
				default:       IO_RDATA_O <= {2'b00, mode_reg,
					rie_reg, mpe_reg, busy_reg, re_reg};
			endcase
		end
	end

	// level interrupt, not a flag: it holds while idle
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ_READY_O <= 1'b0;
		end else begin
			IRQ_READY_O <= rie_reg && GIE_I && !busy_reg;
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I || POR_I);

	sequence s_quiet4;
		(!ctl_wr)[*4];
	endsequence
	sequence s_read_done;
		re_reg ##1 (!re_reg && data_reg == $past(mem_port.rdata));
	endsequence

	chk_mpe_timeout: assert property (
		$rose(mpe_reg) ##0 s_quiet4 |=> !mpe_reg)
		else $error("master enable did not time out");
	chk_mode_frozen: assert property (
		busy_reg && ctl_wr |=> $stable(mode_reg))
		else $error("mode changed while programming");
	chk_strobe_gate: assert property (
		!busy_reg && ctl_wr && IO_WDATA_I[CTL_PE] && !mpe_reg
		|=> !busy_reg)
		else $error("strobe started without master enable");
	chk_write_stall: assert property (
		prog_accept |=> CPU_STALL_O[*2] ##1 !CPU_STALL_O)
		else $error("write stall length wrong");
	chk_read_stall: assert property (
		rd_accept |=> CPU_STALL_O[*4] ##1 !CPU_STALL_O)
		else $error("read stall length wrong");
	chk_read_clear: assert property (
		rd_accept |=> s_read_done)
		else $error("read strobe or data load wrong");
	chk_addr_frozen: assert property (
		busy_reg |=> $stable(addr_reg))
		else $error("address changed while programming");
	chk_irq_busy: assert property (
		busy_reg[*2] |-> !IRQ_READY_O)
		else $error("ready interrupt while busy");
	chk_busy_clear: assert property (
		eng_reg == ENG_COMMIT |=> !busy_reg && eng_reg == ENG_IDLE)
		else $error("strobe not cleared after programming");
	chk_flash_hold: assert property (
		eng_reg == ENG_WAIT && FLASH_SELFPROG_I
		|=> $stable(tick_cnt_reg) && eng_reg != ENG_COMMIT)
		else $error("timer ran during flash programming");
endmodule

// ===== test/ebc_ctrl_tb.sv
// self-checking bench for the eeprom byte access controller
`timescale 1ns/10ps
module ebc_ctrl_tb
	import ebc_pkg::*;
;
	// short tick counts keep each programming run to a few rc periods
	localparam int AT    = 8;
	localparam int ST    = 4;
	localparam int RCP   = 10;
	localparam int LIMIT = 20000;

	logic       CLK_I;
	logic       RST_I;
	logic       POR_I;
	logic [1:0] IO_SEL_I;
	logic       IO_WR_I;
	logic       IO_RD_I;
	logic [7:0] IO_WDATA_I;
	logic [7:0] IO_RDATA_O;
	logic       GIE_I;
	logic       FLASH_SELFPROG_I;
	logic       RC_TICK_I;
	logic       IRQ_READY_O;
	logic       CPU_STALL_O;
	int         miscompares;
	int         samples_checked;
	int         cyc = 0;
	int         stall_cnt = 0;

	ebc_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) i_ebc_ctrl (
		.CLK_I            (CLK_I),
		.RST_I            (RST_I),
		.POR_I            (POR_I),
		.IO_SEL_I         (IO_SEL_I),
		.IO_WR_I          (IO_WR_I),
		.IO_RD_I          (IO_RD_I),
		.IO_WDATA_I       (IO_WDATA_I),
		.IO_RDATA_O       (IO_RDATA_O),
		.GIE_I            (GIE_I),
		.FLASH_SELFPROG_I (FLASH_SELFPROG_I),
		.RC_TICK_I        (RC_TICK_I),
		.IRQ_READY_O      (IRQ_READY_O),
		.CPU_STALL_O      (CPU_STALL_O)
	);

	// ***********************************************************
	// clocks, stall counter and hang guard
	// ***********************************************************
	// rc toggles on falling cpu edges, so its sync never races
	always #10 CLK_I = ~CLK_I;
	always #100 RC_TICK_I = ~RC_TICK_I;

	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (CPU_STALL_O === 1'b1) begin
			stall_cnt <= stall_cnt + 1;
		end
		if (cyc == LIMIT) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ***********************************************************
	// shared tasks
	// ***********************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] d);
		@(posedge CLK_I);
		IO_SEL_I   <= sel;
		IO_WDATA_I <= d;
		IO_WR_I    <= 1'b1;
		@(posedge CLK_I);
		IO_WR_I    <= 1'b0;
	endtask

	// data is registered: sampled one edge after the taking edge
	task automatic rd(input logic [1:0] sel, output logic [7:0] d);
		@(posedge CLK_I);
		IO_SEL_I <= sel;
		IO_RD_I  <= 1'b1;
		@(posedge CLK_I);
		IO_RD_I  <= 1'b0;
		@(posedge CLK_I);
		#1 d = IO_RDATA_O;
	endtask

	task automatic rchk(input string what, input logic [1:0] sel,
		input logic [7:0] exp);
		logic [7:0] v;
		rd(sel, v);
		check(what, {8'h00, exp}, {8'h00, v});
	endtask

	// polls the busy bit under a bound, returns elapsed cycles
	task automatic wait_idle(output int n);
		logic [7:0] v;
		int         t0;
		t0 = cyc;
		v  = 8'h02;
		for (int i = 0; i < 400 && v[CTL_PE] !== 1'b0; i++) begin
			rd(REG_CONTROL, v);
		end
		n = cyc - t0;
	endtask

	// interrupts held off for the timed sequence, restored after it
	task automatic prog(input logic [1:0] m, input logic [7:0] d);
		int   s;
		logic g;
		g = GIE_I;
		@(posedge CLK_I);
		GIE_I <= 1'b0;
		wr(REG_DATA, d);
		wr(REG_CONTROL, {2'b00, m, 4'b1100});
		s = stall_cnt;
		wr(REG_CONTROL, {2'b00, m, 4'b1010});
		repeat (4) @(posedge CLK_I);
		GIE_I <= g;
		check("write stall", 16'd2, 16'(stall_cnt - s));
	endtask

	task automatic rdback(input logic [7:0] exp);
		logic [7:0] v;
		int         s;
		wr(REG_DATA, 8'h00);
		s = stall_cnt;
		wr(REG_CONTROL, 8'h01);
		repeat (6) @(posedge CLK_I);
		check("read stall", 16'd4, 16'(stall_cnt - s));
		rchk("read byte", REG_DATA, exp);
		rd(REG_CONTROL, v);
		check("read strobe", 16'd0, {15'd0, v[CTL_RE]});
	endtask

	task automatic time_ok(input string what, input int n, input int t);
		check(what, 16'd1, {15'd0, n >= (t - 1) * RCP
			&& n <= (t + 1) * RCP + 12});
	endtask

	task automatic pulse_rst();
		@(posedge CLK_I);
		RST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		RST_I <= 1'b0;
	endtask

	// ***********************************************************
	// scenarios
	// ***********************************************************
	task automatic t_regs();
		rchk("ctrl after reset", REG_CONTROL, 8'h00);
		wr(REG_ADDR_HIGH, 8'hFF);
		rchk("addr high unused", REG_ADDR_HIGH, 8'h0F);
		wr(REG_ADDR_LOW, 8'h23);
		wr(REG_ADDR_HIGH, 8'h01);
		rchk("addr low", REG_ADDR_LOW, 8'h23);
		rchk("addr high", REG_ADDR_HIGH, 8'h01);
	endtask

	// a late strobe after the enable lapses must do nothing
	task automatic t_enable();
		int s;
		wr(REG_CONTROL, 8'h04);
		rchk("enable set", REG_CONTROL, 8'h04);
		repeat (4) @(posedge CLK_I);
		rchk("enable lapsed", REG_CONTROL, 8'h00);
		s = stall_cnt;
		wr(REG_CONTROL, 8'h02);
		rchk("late strobe", REG_CONTROL, 8'h00);
		check("late stall", 16'd0, 16'(stall_cnt - s));
	endtask

	task automatic t_atomic();
		int n;
		@(posedge CLK_I);
		GIE_I <= 1'b1;
		wr(REG_CONTROL, 8'h08);
		repeat (2) @(posedge CLK_I);
		check("irq idle", 16'd1, {15'd0, IRQ_READY_O});
		FLASH_SELFPROG_I <= 1'b1;
		prog(MODE_ATOMIC, 8'hA5);
		// let the restored global enable reach the interrupt level
		repeat (2) @(posedge CLK_I);
		check("irq busy", 16'd0, {15'd0, IRQ_READY_O});
		wr(REG_CONTROL, 8'h39);
		wr(REG_ADDR_LOW, 8'h55);
		repeat (AT * RCP * 2) @(posedge CLK_I);
		rchk("held by flash", REG_CONTROL, 8'h0A);
		rchk("addr locked", REG_ADDR_LOW, 8'h23);
		@(posedge CLK_I);
		FLASH_SELFPROG_I <= 1'b0;
		wait_idle(n);
		time_ok("atomic time", n, AT);
		check("irq ready", 16'd1, {15'd0, IRQ_READY_O});
		rchk("busy cleared", REG_CONTROL, 8'h08);
		rdback(8'hA5);
	endtask

	task automatic t_modes();
		int n;
		int s;
		prog(MODE_ERASE, 8'h00);
		wait_idle(n);
		time_ok("erase time", n, ST);
		rdback(8'hFF);
		prog(MODE_WRITE, 8'h3C);
		wait_idle(n);
		time_ok("write time", n, ST);
		rdback(8'h3C);
		prog(MODE_WRITE, 8'h0F);
		wait_idle(n);
		rdback(8'h0C);
		wr(REG_CONTROL, 8'h34);
		s = stall_cnt;
		wr(REG_CONTROL, 8'h32);
		// read lands on the fourth edge, so master enable still shows
		rchk("reserved mode", REG_CONTROL, 8'h34);
		check("reserved stall", 16'd0, 16'(stall_cnt - s));
	endtask

	// reset in mid-programming keeps the mode and the busy bit
	task automatic t_reset();
		int n;
		prog(MODE_ERASE, 8'h00);
		pulse_rst();
		rchk("reset busy", REG_CONTROL, 8'h12);
		wait_idle(n);
		pulse_rst();
		rchk("reset idle", REG_CONTROL, 8'h00);
	endtask

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		CLK_I            = 1'b0;
		RC_TICK_I        = 1'b0;
		RST_I            = 1'b1;
		POR_I            = 1'b1;
		IO_SEL_I         = 2'h0;
		IO_WR_I          = 1'b0;
		IO_RD_I          = 1'b0;
		IO_WDATA_I       = 8'h00;
		GIE_I            = 1'b0;
		FLASH_SELFPROG_I = 1'b0;
		miscompares      = 0;
		samples_checked  = 0;
		repeat (5) @(posedge CLK_I);
		RST_I <= 1'b0;
		POR_I <= 1'b0;
		t_regs();
		t_enable();
		t_atomic();
		t_modes();
		t_reset();
		report_and_stop();
	end
endmodule
